// >>> hdl/bfa_regs.vh
// Register indices, field codes, reset values and bus constants
// for the buffer format and accumulator register bank.
// Assumes a 32-bit AHB-Lite bus; each register index maps to byte address index*4.
`ifndef BFA_REGS_VH
`define BFA_REGS_VH

// Register indices; the byte address is four times the index
`define BFA_IDX_FILL_COUNT     8'h01
`define BFA_IDX_ACCUMULATION_COUNT      8'h02
`define BFA_IDX_CHAN0_LOW      8'h08
`define BFA_IDX_CHAN0_HIGH     8'h09
`define BFA_IDX_CHAN1_LOW      8'h0A
`define BFA_IDX_CHAN1_HIGH     8'h0B
`define BFA_IDX_SEQ_GO         8'h1E
`define BFA_IDX_OUT_FORMAT     8'h28
`define BFA_IDX_SUMMING_EN     8'h30
`define BFA_IDX_ALERT_WINDOW   8'h37

// Reset values
`define BFA_RST_OUT_FORMAT     2'h0
`define BFA_RST_SUMMING_EN     4'h0
`define BFA_RST_WINDOW_ON      1'h0

// Output word format codes
`define BFA_FMT_PLAIN          2'h0
`define BFA_FMT_WITH_ID        2'h1
`define BFA_FMT_ID_VALID       2'h2
`define BFA_FMT_PLAIN_ALT      2'h3

// Summing enable codes
`define BFA_SUM_OFF            4'h0
`define BFA_SUM_ON             4'hF

// Channel identifiers
`define BFA_ID_INPUT_ZERO      3'h0
`define BFA_ID_INPUT_ONE       3'h1

// Buffer depth seen by the fill count
`define BFA_BUF_DEPTH          5'h10

// AHB-Lite codes
`define BFA_HTRANS_NONSEQ      2'h2
`define BFA_HRESP_OKAY         1'h0

`endif

// >>> hdl/bfa_chan_sum.v
// One channel's 16-bit running sum of 12-bit conversion results.
// Assumes i_clear and i_add come from logic on i_mclk.
`timescale 1ns/1ps
module bfa_chan_sum
(
   input  wire        i_mclk,
   input  wire        i_rst,
   input  wire        i_clear,
   input  wire        i_add,
   input  wire [11:0] i_sample,
   output reg  [15:0] o_sum
);

   wire [15:0] base;

   // A sample arriving with the clear starts the new sum instead of being lost
   assign base = i_clear ? 16'h0000 : o_sum;

   always @(posedge i_mclk)
   begin
      if (i_rst)
         o_sum <= 16'h0000;
      else if (i_add)
         o_sum <= base + {4'h0, i_sample};
      else if (i_clear)
         o_sum <= 16'h0000;
   end

endmodule

// >>> hdl/bfa_word_fmt.v
// Builds the 16-bit buffered word from a conversion result.
// Assumes conversion inputs come from logic on i_mclk.
`timescale 1ns/1ps
`include "bfa_regs.vh"
module bfa_word_fmt
(
   input  wire        i_mclk,
   input  wire        i_rst,
   input  wire        i_conv_strobe,
   input  wire [11:0] i_result,
   input  wire        i_channel,
   input  wire        i_data_valid,
   input  wire [1:0]  i_format,
   output reg  [15:0] o_word,
   output reg         o_word_strobe
);

   reg  [15:0] next_word;
   wire [2:0]  chan_id;

   assign chan_id = i_channel ? `BFA_ID_INPUT_ONE : `BFA_ID_INPUT_ZERO;

   always @*
   begin
      case (i_format)
         `BFA_FMT_WITH_ID:  next_word = {i_result, chan_id, 1'b0};
         `BFA_FMT_ID_VALID: next_word = {i_result, chan_id, i_data_valid};
         default:           next_word = {i_result, 4'h0};
      endcase
   end

   always @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_word        <= 16'h0000;
         o_word_strobe <= 1'b0;
      end
      else
      begin
         o_word_strobe <= i_conv_strobe;
         if (i_conv_strobe)
            o_word <= next_word;
      end
   end

endmodule

// >>> hdl/bfa_regbank.v
// Buffer format, fill count and accumulator register bank with an AHB-Lite slave.
// Assumes conversion results and reset requests come from logic on i_mclk
// (20 MHz); the buffer memory itself sits outside and takes o_buffer_word.
// Register words sit at byte address index*4.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "bfa_regs.vh"

module bfa_regbank
(
   input  wire        i_mclk,
   input  wire        i_sys_rst,
   input  wire        i_general_call_rst,
   input  wire        i_device_rst,
   input  wire        i_hsel,
   input  wire [31:0] i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire [31:0] i_hwdata,
   input  wire        i_hready,
   output reg  [31:0] o_hrdata,
   output reg         o_hreadyout,
   output reg         o_hresp,
   input  wire        i_conv_strobe,
   input  wire [11:0] i_conv_result,
   input  wire        i_conv_channel,
   input  wire        i_conv_data_valid,
   output wire [15:0] o_buffer_word,
   output wire        o_buffer_strobe,
   output reg         o_window_comparator_on,
   output reg         o_alert_enable,
   output reg  [1:0]  o_output_format,
   output reg         o_summing_active
);

   // Bus phase tracking
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_READ = 2'b10;

   reg  [1:0]  state;
   reg         wr_pend;
   reg  [7:0]  wr_idx;
   reg         wr_map_ok;
   reg  [7:0]  rd_idx;
   reg         rd_map_ok;

   // Control and status
   reg  [3:0]  summing_enable_code;
   reg  [4:0]  buffer_fill_count;
   reg  [3:0]  accumulation_count;
   reg         sequence_go_bit;

   wire        any_rst;
   wire        addr_take;
   wire        addr_in_map;
   wire        wr_now;
   wire        summing_on;
   wire        add_zero;
   wire        add_one;
   wire [15:0] chan0_sum;
   wire [15:0] chan1_sum;
   wire [4:0]  fill_base;
   wire [3:0]  count_base;
   reg  [31:0] next_rdata;

   // Write strobes and next status values
   reg         wr_format_sel;
   reg         wr_summing_sel;
   reg         wr_window_sel;
   reg         wr_seq_go_sel;
   reg  [4:0]  next_fill;
   reg  [3:0]  next_count;
   wire        rd_take;
   wire        wr_take;
   wire        add_any;

   // Power-up, general call and device resets all act alike
   assign any_rst     = i_sys_rst | i_general_call_rst | i_device_rst;

   assign addr_take   = i_hsel & i_hready & (i_htrans == `BFA_HTRANS_NONSEQ);
   assign addr_in_map = (i_haddr[31:10] == 22'h000000) & (i_haddr[1:0] == 2'h0);
   assign rd_take     = addr_take & ~i_hwrite;
   assign wr_take     = addr_take & i_hwrite;

   assign wr_now      = wr_pend & wr_map_ok;

   // Reserved enable codes fall through as disabled
   assign summing_on  = (summing_enable_code == `BFA_SUM_ON);

   assign add_zero    = i_conv_strobe & summing_on & ~i_conv_channel;
   assign add_one     = i_conv_strobe & summing_on & i_conv_channel;
   assign add_any     = add_zero | add_one;

   // Clear and new count share a cycle: the new event still lands
   assign fill_base   = sequence_go_bit ? 5'h00 : buffer_fill_count;
   assign count_base  = sequence_go_bit ? 4'h0 : accumulation_count;

   // Address phase capture; reads take one wait state so a read right after
   // a write to the same register already sees the written value
   always @(posedge i_mclk)
   begin
      if (any_rst)
      begin
         state       <= ST_IDLE;
         wr_pend     <= 1'b0;
         wr_idx      <= 8'h00;
         wr_map_ok   <= 1'b0;
         rd_idx      <= 8'h00;
         rd_map_ok   <= 1'b0;
         o_hreadyout <= 1'b1;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               // Writes need no wait state: the data phase lands at its closing edge
               wr_pend <= wr_take;
               if (wr_take)
               begin
                  wr_idx    <= i_haddr[9:2];
                  wr_map_ok <= addr_in_map;
               end
               if (rd_take)
               begin
                  rd_idx      <= i_haddr[9:2];
                  rd_map_ok   <= addr_in_map;
                  o_hreadyout <= 1'b0;
                  state       <= ST_READ;
               end
            end
            ST_READ:
            begin
               wr_pend     <= 1'b0;
               o_hreadyout <= 1'b1;
               state       <= ST_IDLE;
            end
            default:
            begin
               wr_pend     <= 1'b0;
               o_hreadyout <= 1'b1;
               state       <= ST_IDLE;
            end
         endcase
      end
   end

   // No refusal exists in this block, so every transfer answers OKAY,
   // unmapped and read-only words included
   always @(posedge i_mclk)
   begin
      o_hresp <= `BFA_HRESP_OKAY;
   end

   // Read mux; reserved bits and unmapped words read as zero
   always @*
   begin
      next_rdata = 32'h00000000;
      if (rd_map_ok)
      begin
         case (rd_idx)
            `BFA_IDX_FILL_COUNT:
               next_rdata = {27'h0000000, buffer_fill_count};
            `BFA_IDX_ACCUMULATION_COUNT:
               next_rdata = {28'h0000000, accumulation_count};
            `BFA_IDX_CHAN0_LOW:
               next_rdata = {24'h000000, chan0_sum[7:0]};
            `BFA_IDX_CHAN0_HIGH:
               next_rdata = {24'h000000, chan0_sum[15:8]};
            `BFA_IDX_CHAN1_LOW:
               next_rdata = {24'h000000, chan1_sum[7:0]};
            `BFA_IDX_CHAN1_HIGH:
               next_rdata = {24'h000000, chan1_sum[15:8]};
            `BFA_IDX_OUT_FORMAT:
               next_rdata = {30'h00000000, o_output_format};
            `BFA_IDX_SUMMING_EN:
               next_rdata = {28'h0000000, summing_enable_code};
            `BFA_IDX_ALERT_WINDOW:
               next_rdata = {31'h00000000, o_window_comparator_on};
            default:
               next_rdata = 32'h00000000;
         endcase
      end
   end

   // Held until the next read completes, as the master samples it only once
   always @(posedge i_mclk)
   begin
      if (any_rst)
         o_hrdata <= 32'h00000000;
      else if (state == ST_READ)
         o_hrdata <= next_rdata;
   end

   // Write strobes, one per writable word; unmapped or read-only words get none
   always @*
   begin
      wr_format_sel  = 1'b0;
      wr_summing_sel = 1'b0;
      wr_window_sel  = 1'b0;
      wr_seq_go_sel  = 1'b0;
      if (wr_now)
      begin
         case (wr_idx)
            `BFA_IDX_OUT_FORMAT:
               wr_format_sel  = 1'b1;
            `BFA_IDX_SUMMING_EN:
               wr_summing_sel = 1'b1;
            `BFA_IDX_ALERT_WINDOW:
               wr_window_sel  = 1'b1;
            `BFA_IDX_SEQ_GO:
               wr_seq_go_sel  = 1'b1;
            default:
               wr_format_sel  = 1'b0;
         endcase
      end
   end

   // Writable control; only the documented field bits are stored
   always @(posedge i_mclk)
   begin
      if (any_rst)
         o_output_format <= `BFA_RST_OUT_FORMAT;
      else if (wr_format_sel)
         o_output_format <= i_hwdata[1:0];
   end

   always @(posedge i_mclk)
   begin
      if (any_rst)
         summing_enable_code <= `BFA_RST_SUMMING_EN;
      else if (wr_summing_sel)
         summing_enable_code <= i_hwdata[3:0];
   end

   // One bit drives both the alert logic and the window comparator
   always @(posedge i_mclk)
   begin
      if (any_rst)
      begin
         o_window_comparator_on <= `BFA_RST_WINDOW_ON;
         o_alert_enable         <= `BFA_RST_WINDOW_ON;
      end
      else if (wr_window_sel)
      begin
         o_window_comparator_on <= i_hwdata[0];
         o_alert_enable         <= i_hwdata[0];
      end
   end

   // Registered so the enable seen outside never glitches on a write
   always @(posedge i_mclk)
   begin
      if (any_rst)
         o_summing_active <= 1'b0;
      else
         o_summing_active <= summing_on;
   end

   // Sequence start is write-only and acts for one cycle
   always @(posedge i_mclk)
   begin
      if (any_rst)
         sequence_go_bit <= 1'b0;
      else
         sequence_go_bit <= wr_seq_go_sel & i_hwdata[0];
   end

   // Next status values; a clear and a new event in one cycle keep the event
   always @*
   begin
      next_fill  = fill_base;
      next_count = count_base;
      if (o_buffer_strobe & (fill_base != `BFA_BUF_DEPTH))
         next_fill = fill_base + 5'h01;
      if (add_any)
         next_count = count_base + 4'h1;
   end

   // Entries written to the buffer; saturates at its depth
   always @(posedge i_mclk)
   begin
      if (any_rst)
         buffer_fill_count <= 5'h00;
      else
         buffer_fill_count <= next_fill;
   end

   // Counts finished accumulations; wraps after fifteen
   always @(posedge i_mclk)
   begin
      if (any_rst)
         accumulation_count <= 4'h0;
      else
         accumulation_count <= next_count;
   end

   bfa_chan_sum u_sum_zero
   (
      .i_mclk   (i_mclk),
      .i_rst    (any_rst),
      .i_clear  (sequence_go_bit),
      .i_add    (add_zero),
      .i_sample (i_conv_result),
      .o_sum    (chan0_sum)
   );

   bfa_chan_sum u_sum_one
   (
      .i_mclk   (i_mclk),
      .i_rst    (any_rst),
      .i_clear  (sequence_go_bit),
      .i_add    (add_one),
      .i_sample (i_conv_result),
      .o_sum    (chan1_sum)
   );

   bfa_word_fmt u_word_fmt
   (
      .i_mclk        (i_mclk),
      .i_rst         (any_rst),
      .i_conv_strobe (i_conv_strobe),
      .i_result      (i_conv_result),
      .i_channel     (i_conv_channel),
      .i_data_valid  (i_conv_data_valid),
      .i_format      (o_output_format),
      .o_word        (o_buffer_word),
      .o_word_strobe (o_buffer_strobe)
   );

endmodule

// >>> tb/bfa_regbank_asserts.sv
// Port-level checks for the register bank.
// Assumes a single bus slave, so hready follows hreadyout.
`timescale 1ns/1ps
`include "bfa_regs.vh"
module bfa_regbank_asserts
(
   input wire        i_mclk,
   input wire        i_sys_rst,
   input wire        i_general_call_rst,
   input wire        i_device_rst,
   input wire        i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0]  i_htrans,
   input wire        i_hwrite,
   input wire [31:0] i_hwdata,
   input wire        i_hready,
   input wire [31:0] o_hrdata,
   input wire        o_hreadyout,
   input wire        i_conv_strobe,
   input wire [11:0] i_conv_result,
   input wire        i_conv_channel,
   input wire        i_conv_data_valid,
   input wire [15:0] o_buffer_word,
   input wire        o_buffer_strobe,
   input wire        o_window_comparator_on,
   input wire        o_alert_enable,
   input wire [1:0]  o_output_format,
   input wire        o_summing_active
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst || i_general_call_rst || i_device_rst);
   sequence s_req(w, a);
      i_hsel && i_hready && i_htrans == `BFA_HTRANS_NONSEQ && i_hwrite == w && i_haddr == a;
   endsequence
   sequence s_wr(a);
      s_req(1'b1, a) ##1 1'b1;
   endsequence
   sequence s_rd_done;
      !o_hreadyout ##1 o_hreadyout;
   endsequence
   property p_strobe; i_conv_strobe |=> o_buffer_strobe; endproperty
   a_strobe: assert property (p_strobe) else $error("buffer strobe missing");
   property p_plain; i_conv_strobe && o_output_format[0] == o_output_format[1]
      |=> o_buffer_word == {$past(i_conv_result), 4'h0}; endproperty
   a_plain: assert property (p_plain) else $error("plain word wrong");
   property p_id; i_conv_strobe && o_output_format == `BFA_FMT_WITH_ID
      |=> o_buffer_word == {$past(i_conv_result), 2'h0, $past(i_conv_channel), 1'b0};
   endproperty
   a_id: assert property (p_id) else $error("word with id wrong");
   property p_valid; i_conv_strobe && o_output_format == `BFA_FMT_ID_VALID
      |=> o_buffer_word == {$past(i_conv_result), 2'h0, $past(i_conv_channel),
      $past(i_conv_data_valid)}; endproperty
   a_valid: assert property (p_valid) else $error("word with valid bit wrong");
   property p_alert; o_alert_enable == o_window_comparator_on; endproperty
   a_alert: assert property (p_alert) else $error("alert and comparator differ");
   property p_window; s_wr({22'h0, `BFA_IDX_ALERT_WINDOW, 2'h0})
      |-> ##2 o_window_comparator_on == $past(i_hwdata[0], 2); endproperty
   a_window: assert property (p_window) else $error("comparator enable wrong");
   property p_sum_on; s_wr({22'h0, `BFA_IDX_SUMMING_EN, 2'h0}) ##0
      i_hwdata[3:0] == `BFA_SUM_ON |-> ##[1:2] o_summing_active; endproperty
   a_sum_on: assert property (p_sum_on) else $error("summing not on");
   property p_sum_off; s_wr({22'h0, `BFA_IDX_SUMMING_EN, 2'h0}) ##0
      i_hwdata[3:0] != `BFA_SUM_ON |-> ##2 !o_summing_active; endproperty
   a_sum_off: assert property (p_sum_off) else $error("summing on by other code");
   property p_unmapped; s_req(1'b0, 32'h0) |=> s_rd_done ##0 o_hrdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_fill; s_req(1'b0, {22'h0, `BFA_IDX_FILL_COUNT, 2'h0})
      |=> s_rd_done ##0 o_hrdata <= 32'h10; endproperty
   a_fill: assert property (p_fill) else $error("fill count out of range");
   property p_count; s_req(1'b0, {22'h0, `BFA_IDX_ACCUMULATION_COUNT, 2'h0})
      |=> s_rd_done ##0 o_hrdata[31:4] == 28'h0; endproperty
   a_count: assert property (p_count) else $error("count upper bits set");
endmodule

bind bfa_regbank bfa_regbank_asserts u_chk (.*);

// >>> tb/bfa_conv_src.sv
// Stand-in for the converter core that feeds finished results.
// Assumes commands change by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module bfa_conv_src
(
   input  wire        i_mclk,
   input  wire        i_go,
   input  wire [11:0] i_result,
   input  wire        i_channel,
   input  wire        i_valid,
   output wire        o_strobe,
   output wire [11:0] o_result,
   output wire        o_channel,
   output wire        o_valid
);
   reg [11:0] last = 12'hA5C;
   // Between strobes the lines carry the inverse, so late sampling shows up
   always @(posedge i_mclk)
   begin
      if (i_go)
         last <= i_result;
   end
   assign o_strobe  = i_go;
   assign o_result  = i_go ? i_result : ~last;
   assign o_channel = i_go ? i_channel : ~i_channel;
   assign o_valid   = i_go ? i_valid : ~i_valid;
endmodule

// >>> tb/bfa_regbank_tb.sv
// Self-checking bench for the register bank: bus access, word format, sums.
// Assumes one bus slave and the conversion source model beside it.
`timescale 1ns/1ps
`include "bfa_regs.vh"
module bfa_regbank_tb;
   reg         i_mclk = 0;
   reg         i_sys_rst = 1;
   reg         i_general_call_rst = 0;
   reg         i_device_rst = 0;
   reg         i_hsel = 0;
   reg  [31:0] i_haddr = 0;
   reg  [1:0]  i_htrans = 0;
   reg         i_hwrite = 0;
   reg  [31:0] i_hwdata = 0;
   reg         go = 0, ch = 0, vld = 0, dp_rd = 0, sum_on;
   reg  [11:0] res = 0;
   reg  [15:0] s0, s1;
   reg  [3:0]  cnt;
   reg  [4:0]  fill;
   reg  [1:0]  fmt;
   reg  [15:0] wq[$];
   reg  [31:0] rq[$];
   wire [31:0] o_hrdata;
   wire [15:0] o_buffer_word;
   wire [11:0] i_conv_result;
   wire [1:0]  o_output_format;
   wire        o_hreadyout, o_hresp, o_buffer_strobe, o_summing_active;
   wire        i_conv_strobe, i_conv_channel, i_conv_data_valid;
   wire        o_window_comparator_on, o_alert_enable;
   integer     seed = 46582, mismatches = 0, n_checks = 0, i, k;
   always #25 i_mclk = ~i_mclk;
   bfa_regbank DUT (.*, .i_hready(o_hreadyout), .i_hsize(3'h2));
   bfa_conv_src SRC (.i_mclk(i_mclk), .i_go(go), .i_result(res), .i_channel(ch),
      .i_valid(vld), .o_strobe(i_conv_strobe), .o_result(i_conv_result),
      .o_channel(i_conv_channel), .o_valid(i_conv_data_valid));
   task check(input string nm, input [31:0] seen, input [31:0] exp);
   begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("FAIL %0s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task finish_test;
   begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   task wait_rdy;
   begin
      @(posedge i_mclk);
      while (o_hreadyout !== 1'b1)
         @(posedge i_mclk);
   end
   endtask
   task xfer(input w, input [7:0] idx, input [31:0] d);
   begin
      i_hsel <= 1'b1;
      i_haddr <= {22'h0, idx, 2'h0};
      i_hwrite <= w;
      i_htrans <= `BFA_HTRANS_NONSEQ;
      wait_rdy;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      wait_rdy;
   end
   endtask
   task rd(input [7:0] idx, input [31:0] exp);
   begin
      rq.push_back(exp);
      xfer(1'b0, idx, 32'h0);
   end
   endtask
   task zero;
   begin
      s0 = 0;
      s1 = 0;
      cnt = 0;
      fill = 0;
   end
   endtask
   task stat;
   begin
      rd(`BFA_IDX_FILL_COUNT, {27'h0, fill});
      rd(`BFA_IDX_ACCUMULATION_COUNT, {28'h0, cnt});
      rd(`BFA_IDX_CHAN0_LOW, {24'h0, s0[7:0]});
      rd(`BFA_IDX_CHAN0_HIGH, {24'h0, s0[15:8]});
      rd(`BFA_IDX_CHAN1_LOW, {24'h0, s1[7:0]});
      rd(`BFA_IDX_CHAN1_HIGH, {24'h0, s1[15:8]});
   end
   endtask
   task conv_n(input integer n);
      reg [11:0] r;
      reg        c, v;
   begin
      for (k = 0; k < n; k = k + 1)
      begin
         r = $random(seed);
         c = $random(seed);
         v = $random(seed);
         wq.push_back((fmt == 1 || fmt == 2) ? {r, 2'h0, c, (fmt == 2) & v} : {r, 4'h0});
         if (sum_on && c)
            s1 = s1 + r;
         if (sum_on && !c)
            s0 = s0 + r;
         cnt = cnt + sum_on;
         if (fill < `BFA_BUF_DEPTH)
            fill = fill + 1;
         go <= 1'b1;
         res <= r;
         ch <= c;
         vld <= v;
         @(posedge i_mclk);
      end
      go <= 1'b0;
   end
   endtask
   always @(posedge i_mclk)
   begin
      if (dp_rd && o_hreadyout === 1'b1)
         check("read", o_hrdata, rq.pop_front());
      if (dp_rd && o_hreadyout === 1'b1)
         check("resp", {31'h0, o_hresp}, `BFA_HRESP_OKAY);
      if (o_hreadyout === 1'b1)
         dp_rd <= i_hsel && i_htrans == `BFA_HTRANS_NONSEQ && !i_hwrite;
      if (o_buffer_strobe === 1'b1)
         check("word", {16'h0, o_buffer_word}, {16'h0, wq.pop_front()});
   end
   initial
   begin
      #(50 * 5000);
      mismatches = mismatches + 1;
      finish_test;
   end
   initial
   begin
      zero;
      sum_on = 0;
      fmt = 0;
      repeat (8) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      @(posedge i_mclk);
      stat;
      rd(`BFA_IDX_SUMMING_EN, 32'h0);
      rd(`BFA_IDX_ALERT_WINDOW, 32'h0);
      rd(8'h00, 32'h0);
      // Upper word bits are random to show reserved bits are dropped
      for (i = 0; i < 4; i = i + 1)
      begin
         fmt = i[1:0];
         xfer(1'b1, `BFA_IDX_OUT_FORMAT, ({$random(seed)} & 32'hFFFFFFFC) | i);
         rd(`BFA_IDX_OUT_FORMAT, {30'h0, fmt});
         conv_n(5);
      end
      stat;
      xfer(1'b1, `BFA_IDX_SUMMING_EN, {$random(seed)} | 32'hF);
      sum_on = 1;
      rd(`BFA_IDX_SUMMING_EN, 32'hF);
      conv_n(20);
      stat;
      xfer(1'b1, `BFA_IDX_CHAN0_LOW, 32'hFFFFFFFF);
      rd(`BFA_IDX_CHAN0_LOW, {24'h0, s0[7:0]});
      xfer(1'b1, `BFA_IDX_SUMMING_EN, 32'hFFFFFFF0);
      sum_on = 0;
      conv_n(3);
      stat;
      xfer(1'b1, `BFA_IDX_SEQ_GO, 32'h1);
      zero;
      stat;
      xfer(1'b1, `BFA_IDX_ALERT_WINDOW, 32'hFFFFFFFF);
      rd(`BFA_IDX_ALERT_WINDOW, 32'h1);
      check("win", {30'h0, o_window_comparator_on, o_alert_enable}, 32'h3);
      xfer(1'b1, `BFA_IDX_ALERT_WINDOW, 32'hFFFFFFFE);
      rd(`BFA_IDX_ALERT_WINDOW, 32'h0);
      check("win", {30'h0, o_window_comparator_on, o_alert_enable}, 32'h0);
      for (i = 0; i < 2; i = i + 1)
      begin
         xfer(1'b1, `BFA_IDX_SUMMING_EN, 32'hF);
         sum_on = 1;
         conv_n(4);
         i_general_call_rst <= (i == 0);
         i_device_rst <= (i == 1);
         @(posedge i_mclk);
         i_general_call_rst <= 1'b0;
         i_device_rst <= 1'b0;
         @(posedge i_mclk);
         zero;
         sum_on = 0;
         fmt = 0;
         stat;
         rd(`BFA_IDX_OUT_FORMAT, 32'h0);
      end
      finish_test;
   end
endmodule
